// File: rtl/psr8_params.svh
// Purpose: Named constants for the eight-stage parallel/serial shift register.
// Assumes: One system clock; all device pins are sampled into that domain.
// Notes:   Definitions only.
`ifndef PSR8_PARAMS_SVH
`define PSR8_PARAMS_SVH
`define PSR8_STAGES      8
`define PSR8_LAST        7
`define PSR8_ZERO8       8'h00
`define PSR8_BUF_DEPTH   2
`define PSR8_SYNC_ZERO   2'h0
`endif

// File: rtl/psr8_pkg.sv
// Purpose: Types shared by the shift register files.
// Assumes: Constants come from psr8_params.svh.
// Notes:   The output word carries the last stage and its complement together.
`include "psr8_params.svh"
package psr8_pkg;
  typedef struct packed {
    logic last;
    logic last_n;
  } psr8_out_t;
  typedef enum logic [2:0] {
    PSR8_LOAD  = 3'h1,
    PSR8_SHIFT = 3'h2,
    PSR8_HOLD  = 3'h4
  } psr8_mode_t;
endpackage

// File: rtl/psr8_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronised reset copy from the top, applied asynchronously.
// Notes:   Full and empty are exact; upstream ready drops when both slots hold data.
`timescale 1ns/1ns
`default_nettype none
`include "psr8_params.svh"
module psr8_buf
  import psr8_pkg::*;
(
  input  wire logic      clock_in,
  input  wire logic      rst_n_in,
  input  wire psr8_out_t in_data_in,
  input  wire logic      in_valid_in,
  output logic           in_ready_out,
  output psr8_out_t      out_data_out,
  output logic           out_valid_out,
  input  wire logic      out_ready_in
);
  psr8_out_t mem [`PSR8_BUF_DEPTH];
  psr8_out_t next_mem [`PSR8_BUF_DEPTH];
  logic [1:0] count;
  logic [1:0] next_count;
  logic       push;
  logic       pop;
  always_comb begin
    push = in_valid_in && (count != 2'h2);
    pop = out_ready_in && (count != 2'h0);
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    next_count = count;
    if (pop) begin
      next_mem[0] = mem[1];
    end
    if (push) begin
      if (count == 2'h0 || (count == 2'h1 && pop)) begin
        next_mem[0] = in_data_in;
      end else begin
        next_mem[1] = in_data_in;
      end
    end
    next_count = count + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem[0] <= '0;
      mem[1] <= '0;
      count <= 2'h0;
    end else begin
      mem[0] <= next_mem[0];
      mem[1] <= next_mem[1];
      count <= next_count;
    end
  end
  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = mem[0];
endmodule
`default_nettype wire

// File: rtl/psr8_shift.sv
// Purpose: Eight-stage parallel-in, serial-out shift register in one clock domain.
// Assumes: Select, clock and data pins are asynchronous to clock_in and pass two flip-flops first.
// Notes:   The two shift clocks are detected as sampled rising edges, so each pin
//          must stay high and low for at least two system clock periods.
`timescale 1ns/1ns
`default_nettype none
`include "psr8_params.svh"
module psr8_shift
  import psr8_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       arst_n_in,
  input  wire logic       shift_sel_in,
  input  wire logic       clk_a_in,
  input  wire logic       clk_b_in,
  input  wire logic       serial_data_in,
  input  wire logic [7:0] par_data_in,
  input  wire logic       out_ready_in,
  output logic            last_stage_out,
  output logic            last_stage_n_out,
  output logic            out_valid_out,
  output logic            stall_out
);
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [1:0] sel_s;
  logic [1:0] ca_s;
  logic [1:0] cb_s;
  logic [1:0] sd_s;
  logic [`PSR8_LAST:0] pd_s0;
  logic [`PSR8_LAST:0] pd_s1;
  logic ca_prev;
  logic cb_prev;
  logic [`PSR8_LAST:0] stages;
  logic [`PSR8_LAST:0] next_stages;
  psr8_mode_t mode;
  logic step;
  logic changed;
  logic buf_ready;
  logic buf_valid;
  psr8_out_t buf_word;
  psr8_out_t word;
  logic q;
  logic q_n;
  logic vld;
  logic next_q;
  logic next_q_n;
  logic next_vld;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync <= `PSR8_SYNC_ZERO;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Only the second stage of each synchroniser is read by logic.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sel_s <= `PSR8_SYNC_ZERO;
      ca_s <= `PSR8_SYNC_ZERO;
      cb_s <= `PSR8_SYNC_ZERO;
      sd_s <= `PSR8_SYNC_ZERO;
      pd_s0 <= `PSR8_ZERO8;
      pd_s1 <= `PSR8_ZERO8;
      ca_prev <= 1'b0;
      cb_prev <= 1'b0;
    end else begin
      sel_s <= {sel_s[0], shift_sel_in};
      ca_s <= {ca_s[0], clk_a_in};
      cb_s <= {cb_s[0], clk_b_in};
      sd_s <= {sd_s[0], serial_data_in};
      pd_s0 <= par_data_in;
      pd_s1 <= pd_s0;
      ca_prev <= ca_s[1];
      cb_prev <= cb_s[1];
    end
  end

  always_comb begin
    step = (ca_s[1] && !ca_prev && !cb_s[1]) || (cb_s[1] && !cb_prev && !ca_s[1]);
    next_stages = stages;
    mode = PSR8_HOLD;
    if (!sel_s[1]) begin
      mode = PSR8_LOAD;
    end else if (step) begin
      mode = PSR8_SHIFT;
    end
    case (mode)
      PSR8_LOAD: begin
        next_stages = pd_s1;
      end
      PSR8_SHIFT: begin
        next_stages = {stages[`PSR8_LAST-1:0], sd_s[1]};
      end
      PSR8_HOLD: begin
        next_stages = stages;
      end
      default: begin
        next_stages = stages;
      end
    endcase
    changed = (next_stages[`PSR8_LAST] != stages[`PSR8_LAST]) || (mode == PSR8_SHIFT);
    word.last = next_stages[`PSR8_LAST];
    word.last_n = !next_stages[`PSR8_LAST];
  end

  // Stages advance when the buffer can take the output word, or when a load leaves the last stage unchanged.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      stages <= `PSR8_ZERO8;
    end else if (buf_ready || !changed) begin
      stages <= next_stages;
    end
  end

  psr8_buf psr8_buf_i (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n),
    .in_data_in    (word),
    .in_valid_in   (changed),
    .in_ready_out  (buf_ready),
    .out_data_out  (buf_word),
    .out_valid_out (buf_valid),
    .out_ready_in  (out_ready_in)
  );

  always_comb begin
    next_q = q;
    next_q_n = q_n;
    next_vld = buf_valid;
    if (buf_valid && out_ready_in) begin
      next_q = buf_word.last;
      next_q_n = buf_word.last_n;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
      q_n <= 1'b1;
      vld <= 1'b0;
      last_stage_out <= 1'b0;
      last_stage_n_out <= 1'b1;
      out_valid_out <= 1'b0;
      stall_out <= 1'b0;
    end else begin
      q <= next_q;
      q_n <= next_q_n;
      vld <= next_vld;
      last_stage_out <= next_q;
      last_stage_n_out <= next_q_n;
      out_valid_out <= next_vld;
      stall_out <= !buf_ready;
    end
  end

  property p_load;
    @(posedge clock_in) disable iff (!rst_n)
      (!sel_s[1] && buf_ready) |=> (stages == $past(pd_s1));
  endproperty
  a_load: assert property (p_load) else $error("parallel load missed");

  property p_shift;
    @(posedge clock_in) disable iff (!rst_n)
      (sel_s[1] && step && buf_ready) |=>
        (stages == {$past(stages[`PSR8_LAST-1:0]), $past(sd_s[1])});
  endproperty
  a_shift: assert property (p_shift) else $error("shift step wrong");

  property p_gate;
    @(posedge clock_in) disable iff (!rst_n)
      (sel_s[1] && ca_s[1] && cb_s[1]) |=> (stages == $past(stages));
  endproperty
  a_gate: assert property (p_gate) else $error("gated clock changed stages");

  property p_hold;
    @(posedge clock_in) disable iff (!rst_n)
      (sel_s[1] && !step) |=> $stable(stages);
  endproperty
  a_hold: assert property (p_hold) else $error("contents changed without clock");

  property p_compl;
    @(posedge clock_in) disable iff (!rst_n)
      last_stage_out != last_stage_n_out;
  endproperty
  a_compl: assert property (p_compl) else $error("outputs not complementary");

  property p_either;
    @(posedge clock_in) disable iff (!rst_n)
      (sel_s[1] && cb_s[1] && !cb_prev && !ca_s[1] && buf_ready) |=>
        (stages == {$past(stages[`PSR8_LAST-1:0]), $past(sd_s[1])});
  endproperty
  a_either: assert property (p_either) else $error("second clock ignored");

  property p_serial;
    @(posedge clock_in) disable iff (!rst_n)
      (sel_s[1] && step && buf_ready) |=> (stages[0] == $past(sd_s[1]));
  endproperty
  a_serial: assert property (p_serial) else $error("serial bit not captured");

  property p_all;
    @(posedge clock_in) disable iff (!rst_n)
      (!sel_s[1] && buf_ready) [*2] |=> (stages[`PSR8_LAST] == $past(pd_s1[`PSR8_LAST]));
  endproperty
  a_all: assert property (p_all) else $error("last stage not loaded");
endmodule
`default_nettype wire

// File: dv/psr8_ctrl_model.sv
// Purpose: Controller model that drives the shift register pins.
// Assumes: Every pin level is held three system cycles, above the sampling limit.
// Notes:   Serial data turns to its inverse once its hold time is over.
`timescale 1ns/1ns
`default_nettype none
module psr8_ctrl_model (
  input  wire logic       clock_in,
  output logic            sel_out,
  output logic            clk_a_out,
  output logic            clk_b_out,
  output logic            ser_out,
  output logic [7:0]      par_out
);
  initial begin
    sel_out = 1'h1;
    clk_a_out = 1'h0;
    clk_b_out = 1'h0;
    ser_out = 1'h0;
    par_out = 8'h00;
  end
  task automatic hold3();
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  task automatic load(input logic [7:0] v);
    sel_out = 1'h0;
    par_out = v;
    hold3();
  endtask
  // Parallel lines flip while shifting, so a stray load is visible.
  task automatic shift(input logic use_b, input logic bit_v);
    sel_out = 1'h1;
    ser_out = bit_v;
    par_out = ~par_out;
    if (use_b) clk_b_out = 1'h1;
    else clk_a_out = 1'h1;
    hold3();
    clk_a_out = 1'h0;
    clk_b_out = 1'h0;
    ser_out = ~bit_v;
    hold3();
  endtask
  task automatic gated(input logic bit_v);
    sel_out = 1'h1;
    ser_out = bit_v;
    clk_a_out = 1'h1;
    hold3();
    clk_b_out = 1'h1;
    hold3();
    ser_out = ~bit_v;
    repeat (2) begin
      clk_a_out = 1'h0;
      hold3();
      clk_a_out = 1'h1;
      hold3();
    end
    clk_a_out = 1'h0;
    hold3();
    clk_b_out = 1'h0;
    hold3();
  endtask
endmodule
`default_nettype wire

// File: dv/test_piso_shift_register_8bit.sv
// Purpose: Self-checking bench for the eight-stage shift register.
// Assumes: The output drains after every step, so no shift step is lost.
// Notes:   Expected stages are kept here and compared on both outputs.
`timescale 1ns/1ns
`default_nettype none
module test_piso_shift_register_8bit;
  logic       clock_in;
  logic       arst_n_in;
  logic       out_ready_in;
  wire logic  sel, clk_a, clk_b, ser, last, last_n, valid, stall;
  wire logic [7:0] par;
  logic [7:0] exp_q;
  int         errors;
  int         checks;
  psr8_ctrl_model psr8_ctrl_model_i (.clock_in(clock_in), .sel_out(sel), .clk_a_out(clk_a),
    .clk_b_out(clk_b), .ser_out(ser), .par_out(par));
  psr8_shift psr8_shift_i (.clock_in(clock_in), .arst_n_in(arst_n_in), .shift_sel_in(sel),
    .clk_a_in(clk_a), .clk_b_in(clk_b), .serial_data_in(ser), .par_data_in(par),
    .out_ready_in(out_ready_in), .last_stage_out(last), .last_stage_n_out(last_n),
    .out_valid_out(valid), .stall_out(stall));
  initial begin
    clock_in = 1'h0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic check(input logic seen, input logic want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("BAD %0t output %b expected %b", $time, seen, want);
    end
  endtask
  task automatic settle();
    int i;
    repeat (4) @(posedge clock_in);
    for (i = 0; i < 20 && valid !== 1'h0; i++) @(posedge clock_in);
    repeat (2) @(posedge clock_in);
    #1;
    check(last, exp_q[7]);
    check(last_n, ~exp_q[7]);
  endtask
  task automatic do_load(input logic [7:0] v);
    psr8_ctrl_model_i.load(v);
    exp_q = v;
    settle();
  endtask
  task automatic step(input logic use_b, input logic b);
    psr8_ctrl_model_i.shift(use_b, b);
    exp_q = {exp_q[6:0], b};
    settle();
  endtask
  // Second word while select stays low shows the load needs no clock.
  task automatic t_load();
    do_load(8'hA5);
    do_load(8'h25);
    for (int k = 0; k < 7; k++) step(k[0], 1'h1);
  endtask
  task automatic t_serial();
    logic [7:0] pat;
    pat = 8'hB4;
    do_load(8'h00);
    for (int k = 7; k >= 0; k--) step(k[0], pat[k]);
    // After eight shifts the first serial bit must stand in the last stage.
    check(last, pat[7]);
  endtask
  task automatic t_gate();
    do_load(8'h40);
    psr8_ctrl_model_i.gated(1'h0);
    exp_q = {exp_q[6:0], 1'h0};
    settle();
  endtask
  // Two pending words fill the buffer; a third change must wait, not vanish.
  task automatic t_hold();
    out_ready_in = 1'h0;
    psr8_ctrl_model_i.load(8'h00);
    repeat (2) @(posedge clock_in);
    #1;
    check(valid, 1'h1);
    check(last, 1'h1);
    psr8_ctrl_model_i.load(8'h80);
    repeat (2) @(posedge clock_in);
    #1;
    check(stall, 1'h1);
    psr8_ctrl_model_i.load(8'h00);
    repeat (200) @(posedge clock_in);
    #1;
    check(last, 1'h1);
    check(last_n, 1'h0);
    out_ready_in = 1'h1;
    exp_q = 8'h00;
    settle();
    check(stall, 1'h0);
    check(valid, 1'h0);
  endtask
  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock_in);
    errors++;
    final_report();
  end
  initial begin
    errors = 0;
    checks = 0;
    exp_q = 8'h00;
    out_ready_in = 1'h1;
    arst_n_in = 1'h0;
    repeat (2) @(posedge clock_in);
    #1;
    arst_n_in = 1'h1;
    repeat (3) @(posedge clock_in);
    #1;
    t_load();
    t_serial();
    t_gate();
    t_hold();
    final_report();
  end
endmodule
`default_nettype wire
